// ---- rtl/fan_lut_entry_seven_bank.sv ----
// entry-seven threshold and duty registers with threshold comparison
// Function
// - threshold top bit reads zero in low resolution, joins value in high
// - threshold spans 0..127.5 half steps high, 0..127 whole degrees low
// - temperature above entry-seven threshold raises exceeded_out; duty_out carries entry-seven duty regardless
// - compare nine temperature bits high resolution, eight bits low
// - threshold always non-negative, sign bit taken as zero
// - lookup temperature offset is added to the programmed threshold
// - duty upper two bits read zero unless high duty mode at 22.5kHz pwm, extend then
// - extended duty bits take effect only at 22.5kHz pwm frequency
// - entry-seven low six duty bits give duty in low resolution
// - entry-six low six duty bits give its duty in low resolution
`default_nettype none
`include "fan_lut_params.svh"
module fan_lut_entry_seven_bank
   import fan_lut_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic wr_en_in,
   input wire logic write_allow_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   // modes
   input wire logic temp_res_high_in,
   input wire logic duty_res_high_in,
   input wire logic pwm_22k5_in,
   // temperature: unsigned, lsb 0.5 degree; offset in whole degrees
   input wire logic [`TEMP_WIDTH-1:0] remote_temp_in,
   input wire logic [7:0] temp_offset_in,
   // lookup result
   output logic exceeded_out,
   output logic [7:0] duty_out,
   output logic [7:0] duty_six_out
);
   lut_regs_t regs;
   res_mode_t temp_mode;
   res_mode_t duty_mode;
   logic [7:0] thr_mask;
   logic [7:0] duty_mask;
   logic ext_ok;
   logic [9:0] thr_full;
   logic [9:0] temp_cmp;
   logic wr_thr;
   logic wr_d7;
   logic wr_d6;

   assign temp_mode = temp_res_high_in ? res_high : res_low;
   assign duty_mode = duty_res_high_in ? res_high : res_low;
   assign ext_ok = (duty_mode == res_high) && pwm_22k5_in;
   assign thr_mask = (temp_mode == res_high) ? 8'hFF : `INT_MASK;
   assign duty_mask = ext_ok ? 8'hFF : `BASE_MASK;
   assign wr_thr = wr_en_in && write_allow_in && (addr_in == `THRESHOLD_SEVEN_ADDR);
   assign wr_d7 = wr_en_in && write_allow_in && (addr_in == `DUTY_SEVEN_ADDR);
   assign wr_d6 = wr_en_in && write_allow_in && (addr_in == `DUTY_SIX_ADDR);

   lut_reg_cell #(.RESET_VALUE(`THRESHOLD_RESET)) thr_cell (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .wr_in(wr_thr), .mask_in(thr_mask),
      .data_in(wdata_in), .value_out(regs.threshold_seven));
   lut_reg_cell #(.RESET_VALUE(`DUTY_RESET)) d7_cell (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .wr_in(wr_d7), .mask_in(duty_mask),
      .data_in(wdata_in), .value_out(regs.duty_seven));
   lut_reg_cell #(.RESET_VALUE(`DUTY_RESET)) d6_cell (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .wr_in(wr_d6), .mask_in(duty_mask),
      .data_in(wdata_in), .value_out(regs.duty_six));

   // threshold in half degrees: high mode bit 7 is the half bit, low mode integer
   always_comb begin
      thr_full = 10'h000;
      if (temp_mode == res_high) begin
         thr_full = {2'b00, regs.threshold_seven[`HALF_BIT-1:0], regs.threshold_seven[`HALF_BIT]};
      end else begin
         thr_full = {2'b00, regs.threshold_seven[`HALF_BIT-1:0], 1'b0};
      end
      thr_full = thr_full + {1'b0, temp_offset_in, 1'b0};
   end

   // low mode drops the half-degree bit of the reading
   always_comb begin
      temp_cmp = {1'b0, remote_temp_in};
      if (temp_mode == res_low) begin
         temp_cmp = {1'b0, remote_temp_in[`TEMP_WIDTH-1:1], 1'b0};
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         exceeded_out <= 1'b0;
         duty_out <= 8'h00;
         duty_six_out <= 8'h00;
      end else begin
         exceeded_out <= temp_cmp > thr_full;
         duty_out <= ext_ok ? regs.duty_seven : (regs.duty_seven & `BASE_MASK);
         duty_six_out <= ext_ok ? regs.duty_six : (regs.duty_six & `BASE_MASK);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else begin
         unique case (addr_in)
            `THRESHOLD_SEVEN_ADDR: rdata_out <= regs.threshold_seven & thr_mask;
            `DUTY_SEVEN_ADDR: rdata_out <= regs.duty_seven & duty_mask;
            `DUTY_SIX_ADDR: rdata_out <= regs.duty_six & duty_mask;
            default: rdata_out <= 8'h00;
         endcase
      end
   end

   // registered flag follows the comparison both ways
   property exceed_follow;
      @(posedge clk_in) disable iff (!rst_n_in)
         (temp_cmp > thr_full) |=> exceeded_out;
   endproperty
   exceed_check_a: assert property (exceed_follow) else $error("exceed not flagged");
   no_exceed_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && !(temp_cmp > thr_full)) |=> !exceeded_out)
      else $error("exceed flagged below threshold");

   // extension bits only in high duty mode at the fast pwm rate
   low_duty_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !$past(ext_ok) |-> duty_out[7:6] == 2'h0)
      else $error("ext bits in low mode");
   ext_needs_pwm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && !pwm_22k5_in) |=> (duty_out[7:6] == 2'h0 && duty_six_out[7:6] == 2'h0))
      else $error("ext bits without fast pwm");
   ext_duty_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && ext_ok) |=> (duty_out == $past(regs.duty_seven)
      && duty_six_out == $past(regs.duty_six)))
      else $error("extended duty not passed");

   // low six duty bits always pass
   duty_six_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rst_n_in |=> duty_six_out[5:0] == $past(regs.duty_six[5:0]))
      else $error("entry six duty wrong");
   duty_seven_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rst_n_in |=> duty_out[5:0] == $past(regs.duty_seven[5:0]))
      else $error("entry seven duty wrong");

   // writes store the masked data, locked writes change nothing
   wr_thr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && wr_thr) |=> regs.threshold_seven == $past(wdata_in & thr_mask))
      else $error("threshold write wrong");
   wr_d7_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && wr_d7) |=> regs.duty_seven == $past(wdata_in & duty_mask))
      else $error("entry seven duty write wrong");
   wr_d6_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && wr_d6) |=> regs.duty_six == $past(wdata_in & duty_mask))
      else $error("entry six duty write wrong");
   no_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && !write_allow_in) |=> $stable(regs))
      else $error("write taken while locked");

   // write followed by a read of the same register
   sequence thr_wr_s;
      (rst_n_in && wr_thr) ##1 (rst_n_in && addr_in == `THRESHOLD_SEVEN_ADDR);
   endsequence
   sequence d7_wr_s;
      (rst_n_in && wr_d7) ##1 (rst_n_in && addr_in == `DUTY_SEVEN_ADDR);
   endsequence
   sequence d6_wr_s;
      (rst_n_in && wr_d6) ##1 (rst_n_in && addr_in == `DUTY_SIX_ADDR);
   endsequence
   property thr_round_p;
      @(posedge clk_in) disable iff (!rst_n_in)
         thr_wr_s |=> rdata_out == ($past(wdata_in & thr_mask, 2) & $past(thr_mask));
   endproperty
   property d7_round_p;
      @(posedge clk_in) disable iff (!rst_n_in)
         d7_wr_s |=> rdata_out == ($past(wdata_in & duty_mask, 2) & $past(duty_mask));
   endproperty
   property d6_round_p;
      @(posedge clk_in) disable iff (!rst_n_in)
         d6_wr_s |=> rdata_out == ($past(wdata_in & duty_mask, 2) & $past(duty_mask));
   endproperty
   thr_round_a: assert property (thr_round_p) else $error("threshold read back wrong");
   d7_round_a: assert property (d7_round_p) else $error("duty read back wrong");
   d6_round_a: assert property (d6_round_p) else $error("entry six read back wrong");

   // read masking by mode
   thr_low_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (addr_in == `THRESHOLD_SEVEN_ADDR && !temp_res_high_in) |=> !rdata_out[7])
      else $error("half bit seen in low mode");
   thr_high_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && addr_in == `THRESHOLD_SEVEN_ADDR && temp_res_high_in)
      |=> rdata_out == $past(regs.threshold_seven))
      else $error("half bit lost in high mode");
   d7_low_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rst_n_in && addr_in == `DUTY_SEVEN_ADDR && !ext_ok) |=> rdata_out[7:6] == 2'h0)
      else $error("ext bits read in low mode");

   // threshold and reading as compared
   sign_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (thr_full - {1'b0, temp_offset_in, 1'b0}) <= 10'h0FF)
      else $error("threshold out of range");
   low_thr_even_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (temp_mode == res_low) |-> !thr_full[0])
      else $error("half step in low mode");
   offset_floor_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      thr_full >= {1'b0, temp_offset_in, 1'b0})
      else $error("offset not applied");
   low_cmp_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !temp_res_high_in |-> !temp_cmp[0])
      else $error("half bit used in low mode");
   high_cmp_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      temp_res_high_in |-> temp_cmp == {1'b0, remote_temp_in})
      else $error("reading cut in high mode");

   // reset values of registers and outputs
   reset_val_a: assert property (@(posedge clk_in)
      !rst_n_in |=> (regs.threshold_seven == `THRESHOLD_RESET
      && regs.duty_seven == `DUTY_RESET && regs.duty_six == `DUTY_RESET))
      else $error("bad reset value");
   reset_out_a: assert property (@(posedge clk_in)
      !rst_n_in |=> (!exceeded_out && duty_out == 8'h00 && duty_six_out == 8'h00
      && rdata_out == 8'h00))
      else $error("outputs not cleared in reset");
endmodule
`default_nettype wire

// ---- rtl/fan_lut_params.svh ----
// offsets, field positions and reset values of the entry-seven lookup bank
`ifndef FAN_LUT_PARAMS_SVH
`define FAN_LUT_PARAMS_SVH
`define THRESHOLD_SEVEN_ADDR 8'h5C
`define DUTY_SEVEN_ADDR 8'h5D
`define DUTY_SIX_ADDR 8'h5B
`define THRESHOLD_RESET 8'h7F
`define DUTY_RESET 8'h3F
`define HALF_BIT 7
`define INT_MASK 8'h7F
`define BASE_MASK 8'h3F
`define EXT_LSB 6
`define TEMP_WIDTH 9
`endif

// ---- rtl/fan_lut_pkg.sv ----
// types shared by the entry-seven lookup bank
`default_nettype none
package fan_lut_pkg;
   typedef struct packed {
      logic [7:0] threshold_seven;
      logic [7:0] duty_seven;
      logic [7:0] duty_six;
   } lut_regs_t;
   typedef enum logic [0:0] {
      res_low = 1'b0,
      res_high = 1'b1
   } res_mode_t;
endpackage
`default_nettype wire

// ---- rtl/lut_reg_cell.sv ----
// one byte register with reset value and write mask
`default_nettype none
module lut_reg_cell #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // write port
   input wire logic wr_in,
   input wire logic [7:0] mask_in,
   input wire logic [7:0] data_in,
   // stored value
   output logic [7:0] value_out
);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         value_out <= RESET_VALUE;
      end else if (wr_in) begin
         value_out <= data_in & mask_in;
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the entry-seven lookup bank
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, rst_n_in, wr_en_in, write_allow_in, temp_res_high_in, duty_res_high_in;
   logic pwm_22k5_in, exceeded_out;
   logic [7:0] addr_in, wdata_in, rdata_out, temp_offset_in, duty_out, duty_six_out;
   logic [8:0] remote_temp_in;
   int failures = 0;
   int compares = 0;
   fan_lut_entry_seven_bank DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en_in),
      .write_allow_in(write_allow_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .rdata_out(rdata_out), .temp_res_high_in(temp_res_high_in),
      .duty_res_high_in(duty_res_high_in), .pwm_22k5_in(pwm_22k5_in),
      .remote_temp_in(remote_temp_in), .temp_offset_in(temp_offset_in),
      .exceeded_out(exceeded_out), .duty_out(duty_out), .duty_six_out(duty_six_out));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_en_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      repeat (2) @(posedge clk_in);
      #1;
      chk("rdata", rdata_out, exp);
   endtask
   // apply a temperature, then check the registered exceeded flag, and entry-seven duty only when exceeded
   task automatic tmp(input logic [8:0] t, input logic exc, input logic [7:0] duty);
      @(posedge clk_in);
      remote_temp_in <= t;
      repeat (2) @(posedge clk_in);
      #1;
      chk("exceeded", {7'h00, exceeded_out}, {7'h00, exc});
      if (exc) chk("duty", duty_out, duty);
   endtask
   task automatic wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
   initial begin
      {rst_n_in, wr_en_in, write_allow_in, temp_res_high_in, duty_res_high_in} = '0;
      {pwm_22k5_in, addr_in, wdata_in, temp_offset_in, remote_temp_in} = '0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(8'h5C, 8'h7F);
      rd(8'h5D, 8'h3F);
      rd(8'h5B, 8'h3F);
      wr(8'h5C, 8'h00);
      rd(8'h5C, 8'h7F);
      @(posedge clk_in);
      write_allow_in <= 1'b1;
      wr(8'h5C, 8'hFF);
      rd(8'h5C, 8'h7F);
      wr(8'h5D, 8'hFF);
      rd(8'h5D, 8'h3F);
      wr(8'h5B, 8'hFF);
      rd(8'h5B, 8'h3F);
      rd(8'h40, 8'h00);
      $display("test registers done");
      @(posedge clk_in);
      temp_res_high_in <= 1'b1;
      duty_res_high_in <= 1'b1;
      wr(8'h5C, 8'h94);
      rd(8'h5C, 8'h94);
      wr(8'h5D, 8'hFF);
      rd(8'h5D, 8'h3F);
      @(posedge clk_in);
      pwm_22k5_in <= 1'b1;
      wr(8'h5D, 8'hFF);
      rd(8'h5D, 8'hFF);
      wr(8'h5B, 8'hC1);
      rd(8'h5B, 8'hC1);
      tmp(9'h029, 1'b0, 8'h00);
      tmp(9'h02A, 1'b1, 8'hFF);
      chk("duty_six", duty_six_out, 8'hC1);
      @(posedge clk_in);
      temp_res_high_in <= 1'b0;
      tmp(9'h029, 1'b0, 8'h00);
      tmp(9'h02A, 1'b1, 8'hFF);
      @(posedge clk_in);
      duty_res_high_in <= 1'b0;
      tmp(9'h02A, 1'b1, 8'h3F);
      chk("duty_six", duty_six_out, 8'h01);
      @(posedge clk_in);
      temp_offset_in <= 8'h0A;
      tmp(9'h02A, 1'b0, 8'h00);
      tmp(9'h03E, 1'b1, 8'h3F);
      tmp(9'h1FF, 1'b1, 8'h3F);
      $display("test lookup done");
      wrap_up();
   end
endmodule
`default_nettype wire
